/* core/iic_arbiter.sv */
// Purpose: picks the winning request by level, then by polling position
// Assumes: pending inputs are already gated by their enables
// Notes: purely combinational
module iic_arbiter
   import iic_pkg::*;
(
   // requests
   input wire logic [13:0] pending,
   input wire logic [13:0] lvl_hi,
   input wire logic [13:0] lvl_lo,
   // active handlers, one marker per level
   input wire logic [3:0] in_service,
   // winner
   output iic_pkg::iic_idx_t win_idx,
   output iic_pkg::iic_lvl_t win_lvl,
   output logic win_valid
);
   import iic_pkg::*;

   logic found;

   always_comb begin
      found = 1'b0;
      win_idx = 4'h0;
      win_lvl = 2'h0;
      // walk from the last source down so equal levels end on the lowest index
      for (int s = 13; s >= 0; s--) begin
         if (pending[s] && (!found || {lvl_hi[s], lvl_lo[s]} >= win_lvl)) begin // [RQ5] [RQ15]
            found = 1'b1;
            win_idx = 4'(s);
            win_lvl = {lvl_hi[s], lvl_lo[s]};
         end
      end
      // a handler at this level or above holds off the request
      win_valid = found && ((in_service >> win_lvl) == 4'h0); // [RQ16] [RQ19]
   end

endmodule

/* core/iic_ctrl.sv */
// Purpose: fourteen-source, four-level interrupt controller with fixed vectors
// Assumes: cpu_ack pulses when the cpu branches to the offered vector, cpu_reti on return
// Notes: register reads answer one cycle after the read strobe
//
// What this block does
// RQ1: fourteen sources, each with a high and low bit choosing one of four levels
// RQ2: software writes to request flags act exactly like hardware updates
// RQ3: service needs both source enable and global enable at bit 7
// RQ4: vector is 0003H plus eight per source, up to 006BH
// RQ5: equal levels resolve in fixed polling order, external 0 first, keypad last
// RQ6: main enable bits 5..0 enable timer2, serial0, timer1, pin1, timer0, pin0
// RQ7: software writes zero to reserved bit 6 of the main enables
// RQ8: pin control bit 7 picks pin 3 polarity, one means high or rising
// RQ9: pin control bit 4 picks level sensing at zero, edge sensing at one
// RQ10: pin 3 flag at bit 5 set on edge, cleared when serviced
// RQ11: pin control bit 6 enables the pin 3 source
// RQ12: pin 2 uses the low nibble the same way as pin 3
// RQ13: extended enables bits 5..0 gate keypad, serial1, brown-out, counter array, converter, spi
// RQ14: software writes zeros to the two reserved top extended enable bits
// RQ15: level code 11 is highest, then 10, then 01, 00 lowest
// RQ16: no preemption by lower level; higher level wins among simultaneous requests
// RQ17: timer 0 and timer 1 flags are cleared on vectoring
// RQ18: timer2 request ORs two flags; peripheral flags stay until software clears
// RQ19: one in-service marker per level, set on vectoring, cleared on return
`include "iic_defs.svh"

module iic_ctrl (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input iic_pkg::iic_sfr_t sfr,
   output logic [7:0] sfr_rdata,
   // peripheral request flags
   input iic_pkg::iic_flags_t flags,
   // external pins, asynchronous
   input wire logic ext_pin_2,
   input wire logic ext_pin_3,
   // cpu side
   input wire logic cpu_ack,
   input wire logic cpu_reti,
   output iic_pkg::iic_offer_t offer,
   // clear pulses to owners of sources 3..0 (timer1, pin1, timer0, pin0)
   output logic [3:0] vector_clear
);
   import iic_pkg::*;

   logic [7:0] main_en_ff, nxt_main_en;
   logic [7:0] ext_en_ff, nxt_ext_en;
   logic [7:0] pin_ctrl_ff, nxt_pin_ctrl;
   logic [7:0] main_lo_ff, nxt_main_lo;
   logic [7:0] main_hi_ff, nxt_main_hi;
   logic [7:0] ext_lo_ff, nxt_ext_lo;
   logic [7:0] ext_hi_ff, nxt_ext_hi;
   logic [7:0] rdata_ff, nxt_rdata;
   logic [1:0] sync1_ff, sync2_ff, prev_ff;
   logic [3:0] in_service_ff, nxt_in_service;
   logic offer_req_ff, nxt_offer_req;
   iic_idx_t offer_idx_ff, nxt_offer_idx;
   iic_lvl_t offer_lvl_ff, nxt_offer_lvl;
   logic [15:0] vector_ff, nxt_vector;
   logic [3:0] clear_ff, nxt_clear;
   logic [13:0] raw_req, src_en, pending;
   logic [1:0] pin_edge;
   logic win_valid;
   iic_idx_t win_idx;
   iic_lvl_t win_lvl;
   logic taken;

   function automatic logic [3:0] drop_top(input logic [3:0] v);
      logic [3:0] r;
      r = v;
      for (int k = 3; k >= 0; k--) begin
         if (v[k] && (v >> (k + 1)) == 4'h0) begin
            r[k] = 1'b0;
         end
      end
      return r;
   endfunction

   function automatic logic pin_active(input logic lvl, input logic pol);
      return pol ? lvl : ~lvl; // [RQ8]
   endfunction

   assign taken = cpu_ack && offer_req_ff;

   // sources in polling order
   always_comb begin
      raw_req = {flags.keypad_match_flag,
                 flags.serial1_receive_flag | flags.serial1_transmit_flag,
                 flags.brownout_flag,
                 flags.counter_wrap_flag | (|flags.module_match_flags),
                 flags.conversion_done_flag,
                 flags.spi_done_flag,
                 pin_ctrl_ff[`IIC_PIN_NIBBLE + `IIC_PIN_FLAG],
                 pin_ctrl_ff[`IIC_PIN_FLAG],
                 flags.timer2_overflow_flag | flags.timer2_external_flag, // [RQ18]
                 flags.serial0_receive_flag | flags.serial0_transmit_flag,
                 flags.timer1_overflow_flag,
                 flags.pin1_request,
                 flags.timer0_overflow_flag,
                 flags.pin0_request}; // [RQ1]
      src_en = {ext_en_ff[5:0], // [RQ13]
                pin_ctrl_ff[`IIC_PIN_NIBBLE + `IIC_PIN_ON], // [RQ11]
                pin_ctrl_ff[`IIC_PIN_ON], // [RQ12]
                main_en_ff[5:0]}; // [RQ6]
      pending = raw_req & src_en & {14{main_en_ff[`IIC_GLOBAL_BIT]}}; // [RQ3]
   end

   iic_arbiter u_arbiter (
      .pending(pending),
      .lvl_hi({ext_hi_ff[5:0], main_hi_ff}),
      .lvl_lo({ext_lo_ff[5:0], main_lo_ff}),
      .in_service(in_service_ff),
      .win_idx(win_idx),
      .win_lvl(win_lvl),
      .win_valid(win_valid)
   );

   // register file and pin flags
   always_comb begin
      nxt_main_en = main_en_ff;
      nxt_ext_en = ext_en_ff;
      nxt_pin_ctrl = pin_ctrl_ff;
      nxt_main_lo = main_lo_ff;
      nxt_main_hi = main_hi_ff;
      nxt_ext_lo = ext_lo_ff;
      nxt_ext_hi = ext_hi_ff;
      pin_edge = 2'b00;
      if (sfr.wr) begin
         unique case (sfr.addr)
            `IIC_ADDR_MAIN_EN: nxt_main_en = sfr.wdata & `IIC_MAIN_EN_MASK; // [RQ7]
            `IIC_ADDR_EXT_EN: nxt_ext_en = sfr.wdata & `IIC_EXT_MASK; // [RQ14]
            `IIC_ADDR_PIN_CTRL: nxt_pin_ctrl = sfr.wdata; // [RQ2]
            `IIC_ADDR_MAIN_LO: nxt_main_lo = sfr.wdata;
            `IIC_ADDR_MAIN_HI: nxt_main_hi = sfr.wdata;
            `IIC_ADDR_EXT_LO: nxt_ext_lo = sfr.wdata & `IIC_EXT_MASK;
            `IIC_ADDR_EXT_HI: nxt_ext_hi = sfr.wdata & `IIC_EXT_MASK;
            default: ;
         endcase
      end
      for (int p = 0; p < 2; p++) begin
         pin_edge[p] = pin_active(sync2_ff[p], pin_ctrl_ff[4 * p + `IIC_PIN_POL])
                       && !pin_active(prev_ff[p], pin_ctrl_ff[4 * p + `IIC_PIN_POL]);
         // mode as written this cycle, so a write of mode and flag together keeps the flag
         if (nxt_pin_ctrl[4 * p + `IIC_PIN_EDGE]) begin
            // edge flag: cleared when its handler is taken, a new edge wins
            if (taken && offer_idx_ff == `IIC_SRC_PIN2 + 4'(p)) begin
               nxt_pin_ctrl[4 * p + `IIC_PIN_FLAG] = 1'b0; // [RQ10]
            end
            if (pin_edge[p]) begin
               nxt_pin_ctrl[4 * p + `IIC_PIN_FLAG] = 1'b1; // [RQ9] [RQ10] [RQ12]
            end
         end else begin
            // level mode: the pin owns the flag, so a write cannot hold it
            nxt_pin_ctrl[4 * p + `IIC_PIN_FLAG] =
               pin_active(sync2_ff[p], pin_ctrl_ff[4 * p + `IIC_PIN_POL]); // [RQ9]
         end
      end
   end

   // read port, reserved bits already stored as zero
   always_comb begin
      nxt_rdata = rdata_ff;
      if (sfr.rd) begin
         unique case (sfr.addr)
            `IIC_ADDR_MAIN_EN: nxt_rdata = main_en_ff;
            `IIC_ADDR_EXT_EN: nxt_rdata = ext_en_ff;
            `IIC_ADDR_PIN_CTRL: nxt_rdata = pin_ctrl_ff;
            `IIC_ADDR_MAIN_LO: nxt_rdata = main_lo_ff;
            `IIC_ADDR_MAIN_HI: nxt_rdata = main_hi_ff;
            `IIC_ADDR_EXT_LO: nxt_rdata = ext_lo_ff;
            `IIC_ADDR_EXT_HI: nxt_rdata = ext_hi_ff;
            default: nxt_rdata = `IIC_RST_BYTE;
         endcase
      end
   end

   // offer to the cpu and in-service markers
   always_comb begin
      nxt_in_service = in_service_ff;
      if (cpu_reti) begin
         nxt_in_service = drop_top(in_service_ff); // [RQ19]
      end
      if (taken) begin
         nxt_in_service[offer_lvl_ff] = 1'b1; // [RQ19]
      end
      // the cycle of acceptance drops the offer so arbitration sees the new markers
      nxt_offer_req = win_valid && !cpu_ack;
      nxt_offer_idx = win_idx;
      nxt_offer_lvl = win_lvl;
      nxt_vector = `IIC_VEC_BASE + (16'(win_idx) << `IIC_VEC_SHIFT); // [RQ4]
      nxt_clear = 4'h0;
      if (taken && offer_idx_ff < 4'h4) begin
         nxt_clear[offer_idx_ff[1:0]] = 1'b1; // [RQ17]
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         main_en_ff <= `IIC_RST_BYTE;
         ext_en_ff <= `IIC_RST_BYTE;
         pin_ctrl_ff <= `IIC_RST_BYTE;
         main_lo_ff <= `IIC_RST_BYTE;
         main_hi_ff <= `IIC_RST_BYTE;
         ext_lo_ff <= `IIC_RST_BYTE;
         ext_hi_ff <= `IIC_RST_BYTE;
         rdata_ff <= `IIC_RST_BYTE;
         sync1_ff <= 2'b11;
         sync2_ff <= 2'b11;
         prev_ff <= 2'b11;
         in_service_ff <= 4'h0;
         offer_req_ff <= 1'b0;
         offer_idx_ff <= 4'h0;
         offer_lvl_ff <= 2'h0;
         vector_ff <= 16'h0000;
         clear_ff <= 4'h0;
      end else begin
         main_en_ff <= nxt_main_en;
         ext_en_ff <= nxt_ext_en;
         pin_ctrl_ff <= nxt_pin_ctrl;
         main_lo_ff <= nxt_main_lo;
         main_hi_ff <= nxt_main_hi;
         ext_lo_ff <= nxt_ext_lo;
         ext_hi_ff <= nxt_ext_hi;
         rdata_ff <= nxt_rdata;
         sync1_ff <= {ext_pin_3, ext_pin_2};
         sync2_ff <= sync1_ff;
         prev_ff <= sync2_ff;
         in_service_ff <= nxt_in_service;
         offer_req_ff <= nxt_offer_req;
         offer_idx_ff <= nxt_offer_idx;
         offer_lvl_ff <= nxt_offer_lvl;
         vector_ff <= nxt_vector;
         clear_ff <= nxt_clear;
      end
   end

   assign sfr_rdata = rdata_ff;
   assign offer = '{req: offer_req_ff, vector: vector_ff};
   assign vector_clear = clear_ff;

   vec_calc_a: assert property (@(posedge clk) disable iff (!resetn) // [RQ4]
      offer_req_ff |-> vector_ff == 16'h0003 + {9'h000, offer_idx_ff, 3'b000})
      else $error("offered vector does not match source");

   global_gate_a: assert property (@(posedge clk) disable iff (!resetn) // [RQ3]
      !main_en_ff[7] ##1 !main_en_ff[7] |-> !offer_req_ff)
      else $error("request offered with global enable low");

   pin3_edge_a: assert property (@(posedge clk) disable iff (!resetn) // [RQ10]
      pin_ctrl_ff[4] && pin_edge[1] |=> pin_ctrl_ff[5])
      else $error("pin 3 edge did not set its flag");

   timer0_clear_a: assert property (@(posedge clk) disable iff (!resetn) // [RQ17]
      cpu_ack && offer_req_ff && offer_idx_ff == 4'h1 |=> vector_clear == 4'b0010 ##1 !vector_clear[1])
      else $error("timer 0 clear pulse wrong");

   marker_set_a: assert property (@(posedge clk) disable iff (!resetn) // [RQ19]
      cpu_ack && offer_req_ff |=> in_service_ff[$past(offer_lvl_ff)] && !offer_req_ff)
      else $error("in-service marker not set on acceptance");

   reserved_read_a: assert property (@(posedge clk) disable iff (!resetn) // [RQ7]
      sfr.rd && sfr.addr == 8'hE8 |=> !sfr_rdata[6])
      else $error("reserved enable bit reads as one");

   no_preempt_a: assert property (@(posedge clk) disable iff (!resetn) // [RQ16]
      offer_req_ff && !$past(cpu_ack) && !$past(cpu_reti) |-> (in_service_ff >> offer_lvl_ff) == 4'h0)
      else $error("offer at or below an active level");

   reti_clear_a: assert property (@(posedge clk) disable iff (!resetn) // [RQ19]
      cpu_reti && !cpu_ack && in_service_ff[3] |=> !in_service_ff[3])
      else $error("return did not clear the top marker");

endmodule

/* core/iic_defs.svh */
// Purpose: addresses, field positions, reset values and vector figures of the controller
// Assumes: special-function register addresses are 8 bits wide
// Notes: definitions only
`ifndef IIC_DEFS_SVH
`define IIC_DEFS_SVH

`define IIC_NUM_SRC 14
`define IIC_ADDR_MAIN_EN 8'hE8
`define IIC_ADDR_EXT_EN 8'hAD
`define IIC_ADDR_PIN_CTRL 8'hC0
`define IIC_ADDR_MAIN_LO 8'hB8
`define IIC_ADDR_MAIN_HI 8'hB7
`define IIC_ADDR_EXT_LO 8'hAE
`define IIC_ADDR_EXT_HI 8'hAF

`define IIC_RST_BYTE 8'h00
`define IIC_MAIN_EN_MASK 8'hBF
`define IIC_EXT_MASK 8'h3F
`define IIC_GLOBAL_BIT 7

// pin control nibble: pin 2 in bits 3..0, pin 3 in bits 7..4
`define IIC_PIN_NIBBLE 4
`define IIC_PIN_POL 3
`define IIC_PIN_ON 2
`define IIC_PIN_FLAG 1
`define IIC_PIN_EDGE 0
`define IIC_SRC_PIN2 4'h6
`define IIC_SRC_PIN3 4'h7

`define IIC_VEC_BASE 16'h0003
`define IIC_VEC_SHIFT 3

`endif

/* core/iic_pkg.sv */
// Purpose: types shared by the interrupt controller files
// Assumes: nothing beyond the constants header
// Notes: carrier structs for the register port, peripheral flags and cpu offer
package iic_pkg;

   typedef logic [1:0] iic_lvl_t;
   typedef logic [3:0] iic_idx_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } iic_sfr_t;

   typedef struct packed {
      logic pin0_request;
      logic pin1_request;
      logic timer0_overflow_flag;
      logic timer1_overflow_flag;
      logic timer2_overflow_flag;
      logic timer2_external_flag;
      logic serial0_receive_flag;
      logic serial0_transmit_flag;
      logic spi_done_flag;
      logic conversion_done_flag;
      logic counter_wrap_flag;
      logic [5:0] module_match_flags;
      logic brownout_flag;
      logic serial1_receive_flag;
      logic serial1_transmit_flag;
      logic keypad_match_flag;
   } iic_flags_t;

   typedef struct packed {
      logic req;
      logic [15:0] vector;
   } iic_offer_t;

endpackage

/* dv/iic_cpu_model.sv */
// Purpose: cpu side partner that accepts offers and returns from handlers
// Assumes: an offer stands until it is accepted
// Notes: ack delay is set by the bench so slow acceptance is exercised too
module iic_cpu_model
   import iic_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // bench controls
   input wire logic [3:0] delay,
   input wire logic ret_req,
   // controller side
   input iic_pkg::iic_offer_t offer,
   output logic cpu_ack,
   output logic cpu_reti,
   // record of accepted vectors
   output logic [15:0] last_vec,
   output logic [7:0] n_taken
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_cnt;
   logic ret_q;
   always @(posedge clk) ret_q <= ret_req;
   // launched on the falling edge so the controller samples a settled pulse
   always @(negedge clk or negedge resetn) begin
      if (!resetn) begin
         cpu_ack <= 1'b0;
         cpu_reti <= 1'b0;
         wait_cnt <= 4'h0;
         last_vec <= 16'h0000;
         n_taken <= 8'h00;
      end else begin
         cpu_reti <= ret_q;
         cpu_ack <= 1'b0;
         if (offer.req === 1'b1 && !cpu_ack) begin
            if (wait_cnt == delay) begin
               cpu_ack <= 1'b1;
               last_vec <= offer.vector;
               n_taken <= n_taken + 8'h01;
               wait_cnt <= 4'h0;
            end else begin
               wait_cnt <= wait_cnt + 4'h1;
            end
         end else begin
            wait_cnt <= 4'h0;
         end
      end
   end
endmodule

/* dv/testbench.sv */
// Purpose: self-checking bench for the interrupt controller
// Assumes: peripheral flags are driven here in place of their owners
// Notes: every handler is closed with a return so level markers stay balanced
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import iic_pkg::*;
   logic clk, resetn, ext_pin_2, ext_pin_3, cpu_ack, cpu_reti, ret_req;
   iic_sfr_t sfr;
   iic_flags_t flags;
   iic_offer_t offer;
   logic [7:0] sfr_rdata, n_taken, base;
   logic [3:0] vector_clear, vc_seen, ack_dly;
   logic [15:0] last_vec;
   int mismatches, tests_run, cycles;
   logic [7:0] addrs [6] = '{8'hE8, 8'hAD, 8'hB8, 8'hB7, 8'hAE, 8'hAF};
   logic [7:0] masks [6] = '{8'hBF, 8'h3F, 8'hFF, 8'hFF, 8'h3F, 8'h3F};

   iic_ctrl DUT (.clk(clk), .resetn(resetn), .sfr(sfr), .sfr_rdata(sfr_rdata),
      .flags(flags), .ext_pin_2(ext_pin_2), .ext_pin_3(ext_pin_3), .cpu_ack(cpu_ack),
      .cpu_reti(cpu_reti), .offer(offer), .vector_clear(vector_clear));
   iic_cpu_model cpu (.clk(clk), .resetn(resetn), .delay(ack_dly), .ret_req(ret_req),
      .offer(offer), .cpu_ack(cpu_ack), .cpu_reti(cpu_reti), .last_vec(last_vec),
      .n_taken(n_taken));

   always #2 clk = ~clk;
   always @(posedge clk) vc_seen <= vc_seen | vector_clear;

   task summarize;
      $display("checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ceiling well above the few hundred cycles the scenarios need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         summarize;
      end
   end

   task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask
   task idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      sfr = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge clk) sfr.wr = 1'b0;
      @(negedge clk);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] exp);
      sfr = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(negedge clk) sfr.rd = 1'b0;
      @(negedge clk) chk("read data", {8'h00, sfr_rdata}, {8'h00, exp});
   endtask
   task take(input logic [15:0] exp);
      for (int i = 0; i < 30 && n_taken == base; i++) @(negedge clk);
      chk("taken count", {8'h00, n_taken}, {8'h00, base + 8'h01});
      chk("vector", last_vec, exp);
   endtask
   task ret;
      ret_req = 1'b1;
      @(negedge clk) ret_req = 1'b0;
      idle(4);
   endtask
   // source index to its request bit; pins 2 and 3 are set by software writes
   task set_flag(input int i, input logic v);
      case (i)
         0: flags.pin0_request = v;
         1: flags.timer0_overflow_flag = v;
         2: flags.pin1_request = v;
         3: flags.timer1_overflow_flag = v;
         4: flags.serial0_receive_flag = v;
         5: flags.timer2_external_flag = v;
         6: wr(8'hC0, v ? 8'h07 : 8'h00);
         7: wr(8'hC0, v ? 8'h70 : 8'h00);
         8: flags.spi_done_flag = v;
         9: flags.conversion_done_flag = v;
         10: flags.counter_wrap_flag = v;
         11: flags.brownout_flag = v;
         12: flags.serial1_receive_flag = v;
         default: flags.keypad_match_flag = v;
      endcase
   endtask

   task t_regs;
      for (int j = 0; j < 6; j++) rd(addrs[j], 8'h00);
      rd(8'hC0, 8'h00);
      // all ones on purpose: reserved positions must not be stored
      for (int j = 0; j < 6; j++) begin
         wr(addrs[j], 8'hFF);
         rd(addrs[j], masks[j]);
         wr(addrs[j], 8'h00);
      end
      wr(8'h55, 8'hFF);
      rd(8'h55, 8'h00);
   endtask

   task t_scan;
      wr(8'hE8, 8'hBF);
      wr(8'hAD, 8'h3F);
      for (int i = 0; i < 14; i++) begin
         base = n_taken;
         vc_seen = 4'h0;
         set_flag(i, 1'b1);
         take(16'h0003 + 16'(8 * i));
         set_flag(i, 1'b0);
         ret;
         chk("vector clear", {12'h000, vc_seen}, (i < 4) ? 16'(1 << i) : 16'h0);
      end
   endtask

   task t_gate;
      base = n_taken;
      wr(8'hE8, 8'h02);
      set_flag(1, 1'b1);
      idle(10);
      chk("masked take", {8'h00, n_taken}, {8'h00, base});
      wr(8'hE8, 8'h82);
      take(16'h000B);
      set_flag(1, 1'b0);
      ret;
   endtask

   task t_order;
      wr(8'hE8, 8'hBF);
      ack_dly = 4'h3;
      base = n_taken;
      set_flag(0, 1'b1);
      set_flag(13, 1'b1);
      take(16'h0003);
      base = n_taken;
      set_flag(0, 1'b0);
      ret;
      take(16'h006B);
      set_flag(13, 1'b0);
      ret;
      wr(8'hAF, 8'h20);
      wr(8'hAE, 8'h20);
      base = n_taken;
      set_flag(0, 1'b1);
      set_flag(13, 1'b1);
      take(16'h006B);
      base = n_taken;
      idle(10);
      chk("preempt", {8'h00, n_taken}, {8'h00, base});
      set_flag(13, 1'b0);
      ret;
      take(16'h0003);
      set_flag(0, 1'b0);
      ret;
      wr(8'hAF, 8'h00);
      wr(8'hAE, 8'h00);
      ack_dly = 4'h0;
   endtask

   task t_pins;
      wr(8'hE8, 8'h80);
      wr(8'hC0, 8'h05);
      base = n_taken;
      ext_pin_2 = 1'b0;
      take(16'h0033);
      idle(2);
      rd(8'hC0, 8'h05);
      ret;
      ext_pin_2 = 1'b1;
      wr(8'hC0, 8'h00);
      base = n_taken;
      wr(8'hC0, 8'hC0);
      take(16'h003B);
      base = n_taken;
      ext_pin_3 = 1'b0;
      // let the level flag fall through the synchroniser before the marker is dropped
      idle(4);
      ret;
      idle(10);
      chk("low pin, high sense", {8'h00, n_taken}, {8'h00, base});
      // rising edge sensing on pin 3
      wr(8'hC0, 8'hD0);
      base = n_taken;
      ext_pin_3 = 1'b1;
      take(16'h003B);
      ret;
      wr(8'hC0, 8'h00);
   endtask

   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      sfr = '0;
      flags = '0;
      ext_pin_2 = 1'b1;
      ext_pin_3 = 1'b1;
      ack_dly = 4'h0;
      ret_req = 1'b0;
      vc_seen = 4'h0;
      base = 8'h00;
      mismatches = 0;
      tests_run = 0;
      cycles = 0;
      repeat (12) @(posedge clk);
      @(negedge clk) resetn = 1'b1;
      idle(2);
      t_regs;
      t_scan;
      t_gate;
      t_order;
      t_pins;
      summarize;
   end
endmodule
